// ===== verilog/cps_regs.svh
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH
// ==========================================================
// data-space addresses of the core registers
`define CPS_ADDR_PTR_ONE 8'h80
`define CPS_ADDR_PTR_TWO 8'h81
`define CPS_ADDR_SLOT_FIRST 8'h82
`define CPS_ADDR_SLOT_SECOND 8'h83
`define CPS_ADDR_SUM 8'hff
// ==========================================================
// widths, depths, cycle counts and vectors
`define CPS_IP_W 12
`define CPS_STACK_DEPTH 6
`define CPS_SHORT_CYCLES 4
`define CPS_RESET_VECTOR 12'hffe
`define CPS_NMI_VECTOR 12'hffc
`endif

// ===== verilog/cps_pkg.sv
`default_nettype none
package cps_pkg;
    // ======================================================
    // types shared by the core state files
    typedef enum logic [2:0] {
        CPS_CTX_NORMAL = 3'b001,
        CPS_CTX_INT = 3'b010,
        CPS_CTX_NMI = 3'b100
    } cps_ctx_t;
    typedef enum logic [7:0] {
        CPS_IP_HOLD = 8'h01,
        CPS_IP_INC = 8'h02,
        CPS_IP_REL = 8'h04,
        CPS_IP_JUMP = 8'h08,
        CPS_IP_CALL = 8'h10,
        CPS_IP_INTR = 8'h20,
        CPS_IP_NMI = 8'h40,
        CPS_IP_RET = 8'h80
    } cps_ip_op_t;
    // request from the sequencer for program-flow updates
    typedef struct packed {
        cps_ip_op_t op;
        logic is_return_from_interrupt;
        logic [11:0] target;
        logic [7:0] offset;
    } cps_flow_t;
    // flag update from the alu
    typedef struct packed {
        logic carry_we;
        logic carry_val;
        logic zero_we;
        logic zero_val;
    } cps_flag_upd_t;
    // data-space access from the sequencer
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cps_data_req_t;
endpackage : cps_pkg
`default_nettype wire

// ===== verilog/cps_stack.sv
`include "cps_regs.svh"
`default_nettype none
module cps_stack #(
    parameter int DEPTH = `CPS_STACK_DEPTH,
    parameter int W = `CPS_IP_W
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [W-1:0] push_val_i,
    output logic [W-1:0] top_o,
    output logic empty_o
);
    import cps_pkg::*;
    // ======================================================
    // shift-register stack, no pointer visible to software
    logic [W-1:0] level [DEPTH]; // contents undefined at reset
    logic [W-1:0] next_level [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] fill; // used only for empty flag
    logic [$clog2(DEPTH+1)-1:0] next_fill;

    // next values: push shifts down, pop shifts up
    always_comb begin
        next_fill = fill;
        for (int i = 0; i < DEPTH; i++) begin
            next_level[i] = level[i];
        end
        if (push_i) begin
            next_level[0] = push_val_i; // see RL18
            for (int i = 1; i < DEPTH; i++) begin
                next_level[i] = level[i-1]; // sixth lost, see RL20
            end
            if (fill != DEPTH[$bits(fill)-1:0]) begin
                next_fill = fill + 1'b1;
            end
        end else if (pop_i && fill != '0) begin
            for (int i = 0; i < DEPTH-1; i++) begin
                next_level[i] = level[i+1]; // see RL19
            end
            next_fill = fill - 1'b1;
        end
    end

    // storage needs no reset, only the occupancy count does
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            level[i] <= next_level[i]; // see RL17
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fill <= '0;
        end else begin
            fill <= next_fill;
        end
    end
    assign top_o = level[0];
    assign empty_o = (fill == '0);

    // pushing makes stack non-empty next cycle
    a_push_not_empty: assert property (@(posedge clock_i)
        disable iff (!rst_b_i) push_i |=> !empty_o) // see RL18
        else $error("stack empty after push");
endmodule : cps_stack
`default_nettype wire

// ===== verilog/cps_flags.sv
`default_nettype none
module cps_flags (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [2:0] ctx_i,
    input wire cps_pkg::cps_flag_upd_t upd_i,
    output logic carry_o,
    output logic zero_o
);
    import cps_pkg::*;
    // ======================================================
    // three banked carry/zero pairs, one per context
    logic [2:0] carry_bank; // normal, interrupt, nonmask
    logic [2:0] zero_bank;
    logic [2:0] next_carry_bank;
    logic [2:0] next_zero_bank;

    // only the active bank is touched; others keep values
    always_comb begin
        next_carry_bank = carry_bank;
        next_zero_bank = zero_bank;
        for (int i = 0; i < 3; i++) begin
            if (ctx_i[i] && upd_i.carry_we) begin
                next_carry_bank[i] = upd_i.carry_val; // see RL14
            end
            if (ctx_i[i] && upd_i.zero_we) begin
                next_zero_bank[i] = upd_i.zero_val; // see RL16
            end
        end
    end
    // flags undefined at reset, so no reset branch
    always_ff @(posedge clock_i) begin
        carry_bank <= next_carry_bank; // see RL11
        zero_bank <= next_zero_bank; // see RL12
    end
    assign carry_o = |(carry_bank & ctx_i);
    assign zero_o = |(zero_bank & ctx_i);

    // interrupt and nonmask carry bits hold while the context is normal
    a_bank_isolated: assert property (@(posedge clock_i)
        disable iff (!rst_b_i)
        ((ctx_i == 3'b001) |=> $stable(carry_bank[2:1]))) // see RL12
        else $error("inactive flag bank changed");
endmodule : cps_flags
`default_nettype wire

// ===== verilog/cps_core_state.sv
// Behaviour
// RL1: sum register at data address ff
// RL2: pointer registers at 80 and 81
// RL3: short slots at 82 and 83
// RL4: short-direct access takes four cycles
// RL5: twelve-bit instruction pointer, 4096 bytes
// RL6: pointer increments after each fetch
// RL7: relative branch adds signed offset
// RL8: loads for jump, call, vectors, returns
// RL9: three independent carry/zero pairs
// RL10: interrupt entry switches pair, return restores
// RL11: context switch never clears flags
// RL12: only active pair readable or writable
// RL13: reset starts in nonmask context
// RL14: carry follows arithmetic carry or borrow
// RL15: bit test and rotate use carry
// RL16: zero set on zero result
// RL17: six twelve-bit stack levels, no pointer
// RL18: call pushes pointer, shifts levels down
// RL19: return pops level one into pointer
// RL20: overflow silently drops oldest address
// RL21: empty return keeps stack, continues
// RL22: software saves data registers itself
// RL23: only context selection defined after reset; code also resets ip_o, stack fill, short timer, rdata_o and hit_o
`include "cps_regs.svh"
`default_nettype none
module cps_core_state #(
    parameter int IP_W = `CPS_IP_W,
    parameter int DEPTH = `CPS_STACK_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire cps_pkg::cps_flow_t flow_i,
    input wire cps_pkg::cps_flag_upd_t flag_i,
    input wire cps_pkg::cps_data_req_t data_i,
    input wire logic [11:0] int_vector_i,
    input wire logic short_req_i,
    output logic [IP_W-1:0] ip_o,
    output logic carry_o,
    output logic zero_o,
    output logic [7:0] rdata_o,
    output logic hit_o,
    output logic short_done_o,
    output logic [2:0] ctx_o
);
    import cps_pkg::*;

    // ======================================================
    // data-space mapped core registers
    logic [7:0] sum_register; // undefined at reset
    logic [7:0] pointer_reg_one;
    logic [7:0] pointer_reg_two;
    logic [7:0] short_slot_first;
    logic [7:0] short_slot_second;
    logic [7:0] next_sum, next_p1, next_p2, next_s1, next_s2;
    logic [7:0] next_rdata;
    logic next_hit;

    // write decode plus registered read mux
    always_comb begin
        next_sum = sum_register;
        next_p1 = pointer_reg_one;
        next_p2 = pointer_reg_two;
        next_s1 = short_slot_first;
        next_s2 = short_slot_second;
        next_rdata = 8'h00;
        next_hit = 1'b1;
        case (data_i.addr)
            `CPS_ADDR_SUM: begin
                next_rdata = sum_register; // see RL1
                if (data_i.wr) next_sum = data_i.wdata;
            end
            `CPS_ADDR_PTR_ONE: begin
                next_rdata = pointer_reg_one; // see RL2
                if (data_i.wr) next_p1 = data_i.wdata;
            end
            `CPS_ADDR_PTR_TWO: begin
                next_rdata = pointer_reg_two;
                if (data_i.wr) next_p2 = data_i.wdata;
            end
            `CPS_ADDR_SLOT_FIRST: begin
                next_rdata = short_slot_first; // see RL3
                if (data_i.wr) next_s1 = data_i.wdata;
            end
            `CPS_ADDR_SLOT_SECOND: begin
                next_rdata = short_slot_second;
                if (data_i.wr) next_s2 = data_i.wdata;
            end
            // other addresses belong to ram or peripherals
            default: next_hit = 1'b0;
        endcase
    end

    // contents need no reset; software must initialise
    always_ff @(posedge clock_i) begin
        sum_register <= next_sum; // see RL23
        pointer_reg_one <= next_p1;
        pointer_reg_two <= next_p2;
        short_slot_first <= next_s1;
        short_slot_second <= next_s2;
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
            hit_o <= 1'b0;
        end else begin
            rdata_o <= next_rdata;
            hit_o <= next_hit;
        end
    end

    // ======================================================
    // short-direct access timer: one-byte op, four cycles
    logic [1:0] short_cnt;
    logic short_busy;
    logic [1:0] next_short_cnt;
    logic next_short_busy, next_short_done;

    // counts four cycles from request to done pulse
    always_comb begin
        next_short_cnt = short_cnt;
        next_short_busy = short_busy;
        next_short_done = 1'b0;
        if (short_busy) begin
            if (short_cnt == 2'(`CPS_SHORT_CYCLES - 1)) begin
                next_short_busy = 1'b0; // see RL4
                next_short_done = 1'b1;
                next_short_cnt = 2'h0;
            end else begin
                next_short_cnt = short_cnt + 2'h1;
            end
        end else if (short_req_i) begin
            next_short_busy = 1'b1;
            next_short_cnt = 2'h1;
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            short_cnt <= 2'h0;
            short_busy <= 1'b0;
            short_done_o <= 1'b0;
        end else begin
            short_cnt <= next_short_cnt;
            short_busy <= next_short_busy;
            short_done_o <= next_short_done;
        end
    end

    // ======================================================
    // context selection with a two-level return history
    cps_ctx_t ctx, next_ctx;
    cps_ctx_t prev_ctx, next_prev_ctx; // context to return to
    cps_ctx_t prev2_ctx, next_prev2_ctx; // under nmi over int

    // entry saves current context; return_from_interrupt restores it
    always_comb begin
        next_ctx = ctx;
        next_prev_ctx = prev_ctx;
        next_prev2_ctx = prev2_ctx;
        case (flow_i.op)
            CPS_IP_INTR: begin
                next_prev2_ctx = prev_ctx;
                next_prev_ctx = ctx;
                next_ctx = CPS_CTX_INT; // see RL10
            end
            CPS_IP_NMI: begin
                next_prev2_ctx = prev_ctx;
                next_prev_ctx = ctx;
                next_ctx = CPS_CTX_NMI;
            end
            CPS_IP_RET: begin
                if (flow_i.is_return_from_interrupt) begin
                    next_ctx = prev_ctx; // see RL10
                    next_prev_ctx = prev2_ctx;
                    next_prev2_ctx = CPS_CTX_NORMAL;
                end
            end
            default: ;
        endcase
    end
    // reset enters nonmask context, returning to normal
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctx <= CPS_CTX_NMI; // see RL13
            prev_ctx <= CPS_CTX_NORMAL;
            prev2_ctx <= CPS_CTX_NORMAL;
            ctx_o <= 3'b100;
        end else begin
            ctx <= next_ctx;
            prev_ctx <= next_prev_ctx;
            prev2_ctx <= next_prev2_ctx;
            ctx_o <= next_ctx;
        end
    end

    // ======================================================
    // banked flags; alu drives bit test and rotate values
    logic carry_q, zero_q;
    cps_flags u_flags (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ctx_i(ctx), // see RL9
        .upd_i(flag_i), // see RL15
        .carry_o(carry_q),
        .zero_o(zero_q)
    );
    assign carry_o = carry_q;
    assign zero_o = zero_q;

    // ======================================================
    // return stack and instruction pointer
    logic push, pop, st_empty;
    logic [IP_W-1:0] st_top;
    logic [IP_W-1:0] next_ip;

    assign push = (flow_i.op == CPS_IP_CALL) ||
        (flow_i.op == CPS_IP_INTR) || (flow_i.op == CPS_IP_NMI);
    assign pop = (flow_i.op == CPS_IP_RET);

    cps_stack #(.DEPTH(DEPTH), .W(IP_W)) u_stack (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .push_i(push), // see RL18
        .pop_i(pop), // see RL19
        .push_val_i(ip_o),
        .top_o(st_top),
        .empty_o(st_empty)
    );

    // pointer update sources by flow request
    always_comb begin
        next_ip = ip_o;
        case (flow_i.op)
            CPS_IP_HOLD: next_ip = ip_o;
            CPS_IP_INC: next_ip = ip_o + 12'h001; // see RL6
            CPS_IP_REL: next_ip = ip_o +
                {{4{flow_i.offset[7]}}, flow_i.offset}; // see RL7
            CPS_IP_JUMP: next_ip = flow_i.target; // see RL8
            CPS_IP_CALL: next_ip = flow_i.target;
            CPS_IP_INTR: next_ip = int_vector_i;
            CPS_IP_NMI: next_ip = `CPS_NMI_VECTOR;
            // empty stack: fall through to next, see RL21
            CPS_IP_RET: next_ip = st_empty ? ip_o + 12'h001 : st_top;
            default: next_ip = ip_o;
        endcase
    end
    // reset loads reset vector, 12-bit wraps at 4096
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ip_o <= `CPS_RESET_VECTOR; // see RL5
        end else begin
            ip_o <= next_ip;
        end
    end

    // ======================================================
    // checks
    a_ip_increment: assert property (@(posedge clock_i)
        disable iff (!rst_b_i)
        flow_i.op == CPS_IP_INC |=> ip_o == $past(ip_o) + 12'h001)
        else $error("pointer did not increment"); // see RL6
    a_return_from_interrupt_ctx_back: assert property (@(posedge clock_i)
        disable iff (!rst_b_i)
        (flow_i.op == CPS_IP_INTR) ##1 (flow_i.op == CPS_IP_RET &&
        flow_i.is_return_from_interrupt) |=> ctx_o == $past(ctx_o, 2))
        else $error("context not restored"); // see RL10
    a_call_ret_pair: assert property (@(posedge clock_i)
        disable iff (!rst_b_i)
        (flow_i.op == CPS_IP_CALL) ##1 (flow_i.op == CPS_IP_RET)
        |=> ip_o == $past(ip_o, 2))
        else $error("return address wrong"); // see RL19
    a_short_four: assert property (@(posedge clock_i)
        disable iff (!rst_b_i)
        (short_req_i && !short_busy) |=> !short_done_o [*3] ##1
        short_done_o) else $error("short access not four"); // see RL4
endmodule : cps_core_state
`default_nettype wire

// ===== bench/cps_seq_model.sv
`default_nettype none
// ==========================================================
// sequencer and alu stand-in: one request per call, two for flow2
module cps_seq_model
    import cps_pkg::*;
(
    input wire logic clock_i,
    output var cps_pkg::cps_flow_t flow_o,
    output var cps_pkg::cps_flag_upd_t flag_o,
    output var cps_pkg::cps_data_req_t data_o,
    output var logic [11:0] int_vec_o,
    output var logic short_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero, before reset lets go
    initial begin
        flow_o = {CPS_IP_HOLD, 1'b0, 12'h000, 8'h00};
        flag_o = 4'h0;
        data_o = {1'b0, 8'h00, 8'h00};
        int_vec_o = 12'h000;
        short_o = 1'b0;
    end

    // flow request; vector rides on target for interrupts
    task automatic flow(input cps_ip_op_t op, input logic [11:0] tgt,
                        input logic [7:0] off, input logic return_from_interrupt);
        @(posedge clock_i);
        flow_o <= {op, return_from_interrupt, tgt, off};
        int_vec_o <= tgt;
        @(posedge clock_i);
        flow_o <= {CPS_IP_HOLD, 1'b0, 12'h000, 8'h00};
        int_vec_o <= ~tgt;
    endtask : flow

    // two requests on consecutive edges, then idle
    task automatic flow2(input cps_ip_op_t op_a, input logic [11:0] tgt_a,
                         input cps_ip_op_t op_b, input logic return_from_interrupt_b);
        @(posedge clock_i);
        flow_o <= {op_a, 1'b0, tgt_a, 8'h00};
        int_vec_o <= tgt_a;
        @(posedge clock_i);
        flow_o <= {op_b, return_from_interrupt_b, 12'h000, 8'h00};
        int_vec_o <= ~tgt_a;
        @(posedge clock_i);
        flow_o <= {CPS_IP_HOLD, 1'b0, 12'h000, 8'h00};
    endtask : flow2

    // alu flag result; no save of data registers here
    task automatic flag(input logic cw, input logic cv,
                        input logic zw, input logic zv);
        @(posedge clock_i);
        flag_o <= {cw, cv, zw, zv};
        @(posedge clock_i);
        flag_o <= {1'b0, ~cv, 1'b0, ~zv};
    endtask : flag

    // data access; released write data is inverted, not held
    task automatic data(input logic wr, input logic [7:0] addr,
                        input logic [7:0] wd);
        @(posedge clock_i);
        data_o <= {wr, addr, wd};
        @(posedge clock_i);
        data_o <= {1'b0, 8'h00, ~wd};
    endtask : data

    // single-cycle short-direct start pulse
    task automatic short;
        @(posedge clock_i);
        short_o <= 1'b1;
        @(posedge clock_i);
        short_o <= 1'b0;
    endtask : short
endmodule : cps_seq_model
`default_nettype wire

// ===== bench/cps_pc_flags_stack_tb.sv
`default_nettype none
// ==========================================================
// self-checking bench for the core state block
module cps_pc_flags_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cps_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    cps_flow_t flow;
    cps_flag_upd_t fl;
    cps_data_req_t dreq;
    logic [11:0] ivec;
    logic sreq;
    logic [11:0] ip_o;
    logic carry_o, zero_o, hit_o, short_done_o;
    logic [7:0] rdata_o;
    logic [2:0] ctx_o;
    int error_cnt = 0; // mismatches
    int samples_checked = 0; // comparisons
    logic [11:0] exp_ip; // model of the pointer

    // ======================================================
    // clock and instances
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    cps_seq_model seq_u (.clock_i(clock_i), .flow_o(flow), .flag_o(fl),
        .data_o(dreq), .int_vec_o(ivec), .short_o(sreq));
    cps_core_state dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .flow_i(flow), .flag_i(fl), .data_i(dreq), .int_vector_i(ivec),
        .short_req_i(sreq), .ip_o(ip_o), .carry_o(carry_o),
        .zero_o(zero_o), .rdata_o(rdata_o), .hit_o(hit_o),
        .short_done_o(short_done_o), .ctx_o(ctx_o));

    // ======================================================
    // compare and close
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // flags and context together, since flags follow context
    task automatic chk_cz(input logic [2:0] cx, input logic c,
                          input logic z);
        check({9'h000, ctx_o}, {9'h000, cx});
        check({10'h000, carry_o, zero_o}, {10'h000, c, z});
    endtask : chk_cz
    task automatic op(input cps_ip_op_t o, input logic [11:0] t,
                      input logic [7:0] f, input logic r);
        seq_u.flow(o, t, f, r);
        #1;
    endtask : op

    // ======================================================
    // scenarios
    task automatic t_flow;
        exp_ip = 12'hfff;
        op(CPS_IP_INC, 12'h000, 8'h00, 1'b0);
        check(ip_o, exp_ip);
        op(CPS_IP_INC, 12'h000, 8'h00, 1'b0);
        check(ip_o, 12'h000);
        op(CPS_IP_JUMP, 12'h123, 8'h00, 1'b0);
        check(ip_o, 12'h123);
        op(CPS_IP_REL, 12'h000, 8'hfe, 1'b0);
        check(ip_o, 12'h121);
        op(CPS_IP_REL, 12'h000, 8'h10, 1'b0);
        check(ip_o, 12'h131);
        exp_ip = 12'h131;
        $display("flow test done");
    endtask : t_flow

    // seven calls overflow six levels, then drain past empty
    task automatic t_stack;
        logic [11:0] pushed [0:6];
        for (int i = 0; i < 7; i++) begin
            pushed[i] = exp_ip;
            exp_ip = 12'h200 + 12'(i * 16);
            op(CPS_IP_CALL, exp_ip, 8'h00, 1'b0);
            check(ip_o, exp_ip);
        end
        for (int i = 6; i > 0; i--) begin
            op(CPS_IP_RET, 12'h000, 8'h00, 1'b0);
            check(ip_o, pushed[i]);
        end
        // oldest address was dropped, so the stack is now empty
        op(CPS_IP_RET, 12'h000, 8'h00, 1'b0);
        exp_ip = pushed[1] + 12'h001;
        check(ip_o, exp_ip);
        check({9'h000, ctx_o}, {9'h000, CPS_CTX_NMI});
        $display("stack test done");
    endtask : t_stack

    task automatic t_flags;
        logic [11:0] back;
        seq_u.flag(1'b1, 1'b1, 1'b1, 1'b0);
        #1;
        chk_cz(3'b100, 1'b1, 1'b0);
        seq_u.flag(1'b0, 1'b0, 1'b1, 1'b1);
        #1;
        chk_cz(3'b100, 1'b1, 1'b1);
        op(CPS_IP_RET, 12'h000, 8'h00, 1'b1);
        check({9'h000, ctx_o}, 12'h001);
        back = exp_ip + 12'h001;
        seq_u.flag(1'b1, 1'b0, 1'b1, 1'b1);
        #1;
        chk_cz(3'b001, 1'b0, 1'b1);
        op(CPS_IP_INTR, 12'h3a0, 8'h00, 1'b0);
        check(ip_o, 12'h3a0);
        seq_u.flag(1'b1, 1'b1, 1'b1, 1'b0);
        #1;
        chk_cz(3'b010, 1'b1, 1'b0);
        op(CPS_IP_NMI, 12'h000, 8'h00, 1'b0);
        check(ip_o, 12'hffc);
        chk_cz(3'b100, 1'b1, 1'b1);
        op(CPS_IP_RET, 12'h000, 8'h00, 1'b1);
        check(ip_o, 12'h3a0);
        chk_cz(3'b010, 1'b1, 1'b0);
        op(CPS_IP_RET, 12'h000, 8'h00, 1'b1);
        check(ip_o, back);
        chk_cz(3'b001, 1'b0, 1'b1);
        $display("flag test done");
    endtask : t_flags

    // call and interrupt each answered by an immediate return
    task automatic t_b2b;
        op(CPS_IP_JUMP, 12'h456, 8'h00, 1'b0);
        check(ip_o, 12'h456);
        seq_u.flow2(CPS_IP_CALL, 12'h3c0, CPS_IP_RET, 1'b0);
        #1;
        check(ip_o, 12'h456);
        check({9'h000, ctx_o}, 12'h001);
        seq_u.flow2(CPS_IP_INTR, 12'h5e0, CPS_IP_RET, 1'b1);
        #1;
        check(ip_o, 12'h456);
        check({9'h000, ctx_o}, 12'h001);
        $display("back-to-back test done");
    endtask : t_b2b

    // five mapped places, then two unmapped ones
    task automatic t_data;
        logic [7:0] adr [0:6];
        logic [7:0] val [0:6];
        adr = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84, 8'h7f};
        val = '{8'h11, 8'h22, 8'h44, 8'h88, 8'h5a, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            seq_u.data(1'b1, adr[i], val[i]);
        end
        for (int i = 0; i < 7; i++) begin
            seq_u.data(1'b0, adr[i], 8'h00);
            #1;
            check({4'h0, rdata_o}, {4'h0, val[i]});
            check({11'h000, hit_o}, {11'h000, i < 5});
        end
        $display("data test done");
    endtask : t_data

    task automatic t_short;
        logic [11:0] n;
        seq_u.short();
        #1;
        n = 12'h001;
        while (short_done_o !== 1'b1 && n < 12'h010) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(n, 12'h004);
        @(posedge clock_i);
        #1;
        check({11'h000, short_done_o}, 12'h000);
        // a second start while busy must be ignored
        seq_u.short();
        seq_u.short();
        @(posedge clock_i);
        #1;
        check({11'h000, short_done_o}, 12'h001);
        n = 12'h000;
        repeat (6) begin
            @(posedge clock_i);
            #1;
            if (short_done_o !== 1'b0) begin
                n++;
            end
        end
        check(n, 12'h000);
        $display("short test done");
    endtask : t_short

    // ======================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clock_i);
        #1;
        check(ip_o, 12'hffe);
        check({9'h000, ctx_o}, 12'h004);
        check({11'h000, short_done_o}, 12'h000);
        check({3'h0, hit_o, rdata_o}, 12'h000);
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_flow();
        t_stack();
        t_flags();
        t_b2b();
        t_data();
        t_short();
        close_out();
    end
    initial begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule : cps_pc_flags_stack_tb
`default_nettype wire
